// file: rtl/irvm_consts.vh
/*
 constants for the interrupt request and vector map block.
 assumes inclusion by bare name from rtl files.
*/
`ifndef IRVM_CONSTS_VH
`define IRVM_CONSTS_VH

// vector numbers
`define IRVM_VEC_RESET     2'h0
`define IRVM_VEC_NMI       2'h1
`define IRVM_VEC_VLM       2'h2
`define IRVM_VEC_RTC       2'h3

// program word addresses of the vectors
`define IRVM_ADDR_RESET    8'h00
`define IRVM_ADDR_NMI      8'h02
`define IRVM_ADDR_VLM      8'h04
`define IRVM_ADDR_RTC      8'h06

// flag and enable bit positions
`define IRVM_BIT_NMI       0
`define IRVM_BIT_VLM       1
`define IRVM_BIT_RTC_OVF   2
`define IRVM_BIT_RTC_CMP   3
`define IRVM_NSRC          4

// reset values
`define IRVM_FLAG_RST      4'h0
`define IRVM_EN_RST        4'h0

`endif

// file: rtl/irvm_flag_cell.v
/*
 one sticky interrupt flag with enable and request gating.
 assumes set and clear pulses synchronous to CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none

module irvm_flag_cell (
	// clock and reset
	input  wire clk,
	input  wire rst,
	// source and software controls
	input  wire set_pulse,
	input  wire clear_pulse,
	input  wire enable_write,
	input  wire enable_value,
	// state
	output reg  flag,
	output reg  enable,
	output wire request
);

	always @(posedge clk) begin
		if (rst) begin
			flag   <= 1'b0;
			enable <= 1'b0;
		end else begin
			if (set_pulse)
				flag <= 1'b1;
			else if (clear_pulse)
				flag <= 1'b0;
			if (enable_write)
				enable <= enable_value;
		end
	end

	assign request = flag & enable;

endmodule

`default_nettype wire

// file: rtl/irvm_top.v
/*
 interrupt request generation and fixed vector mapping for four sources:
 memory scan nmi, voltage level monitor, rtc overflow and rtc compare.
 one sticky flag cell per source, per vector gating, lowest vector wins,
 and the word address of the winning vector, all registered on CLOCK.
 assumes peripherals give one-cycle condition pulses on CLOCK, that
 software clear and enable strobes arrive as ports on CLOCK, and that
 the core reads the registered vector and address as levels.
 flags and requests show two edges after the input edge, vlm and rtc requests one edge after a GLOBAL_ENABLE edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irvm_consts.vh"

module irvm_top (
	// clock and reset
	input  wire       CLOCK,
	input  wire       SYS_RST,
	// peripheral condition pulses
	input  wire       SCAN_FAIL,
	input  wire       VLM_EVENT,
	input  wire       RTC_OVF_EVENT,
	input  wire       RTC_CMP_EVENT,
	// flag clear pulses, one bit per source
	input  wire [3:0] FLAG_CLEAR,
	// enable writes, one bit per source
	input  wire [3:0] ENABLE_WRITE,
	input  wire [3:0] ENABLE_VALUE,
	// global enable
	input  wire       GLOBAL_ENABLE,
	// state seen by software
	output reg  [3:0] INTERRUPT_FLAG_REGISTER,
	output reg  [3:0] INTERRUPT_ENABLE_REGISTER,
	// per vector requests toward the core
	output reg        MEMORY_SCAN_NONMASKABLE_IRQ,
	output reg        VOLTAGE_LEVEL_MONITOR_IRQ,
	output reg        RTC_COUNTER_IRQ,
	// highest priority pending vector
	output reg        IRQ_PENDING,
	output reg  [1:0] IRQ_VECTOR,
	output reg  [7:0] IRQ_ADDRESS
);

	wire [3:0] set_src;
	wire [3:0] flag;
	wire [3:0] enable;
	wire [3:0] request;
	reg        next_nmi;
	reg        next_vlm;
	reg        next_rtc;
	reg        next_pending;
	reg  [1:0] next_vector;
	reg  [7:0] next_address;
	reg  [3:0] next_flag_reg;
	reg  [3:0] next_enable_reg;
	reg  [2:0] vector_hits;
	wire       rtc_request;

	////////////////////////////////////////////////////////////////////////
	// sources and flags

	assign set_src[`IRVM_BIT_NMI]     = SCAN_FAIL;
	assign set_src[`IRVM_BIT_VLM]     = VLM_EVENT;
	assign set_src[`IRVM_BIT_RTC_OVF] = RTC_OVF_EVENT;
	assign set_src[`IRVM_BIT_RTC_CMP] = RTC_CMP_EVENT;

	genvar i;
	generate
		for (i = 0; i < `IRVM_NSRC; i = i + 1) begin : g_src
			irvm_flag_cell u_cell (
				.clk          (CLOCK),
				.rst          (SYS_RST),
				.set_pulse    (set_src[i]),
				.clear_pulse  (FLAG_CLEAR[i]),
				.enable_write (ENABLE_WRITE[i]),
				.enable_value (ENABLE_VALUE[i]),
				.flag         (flag[i]),
				.enable       (enable[i]),
				.request      (request[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// vector requests and selection

	assign rtc_request = request[`IRVM_BIT_RTC_OVF] | request[`IRVM_BIT_RTC_CMP];

	// software view of flags and enables
	always @* begin
		next_flag_reg   = flag;
		next_enable_reg = enable;
	end

	// per vector gating
	always @* begin
		next_nmi     = request[`IRVM_BIT_NMI];
		next_vlm     = request[`IRVM_BIT_VLM] & GLOBAL_ENABLE;
		next_rtc     = rtc_request & GLOBAL_ENABLE;
		next_pending = next_nmi | next_vlm | next_rtc;
		vector_hits  = {next_nmi, next_vlm, next_rtc};
	end

	// lowest vector number wins
	always @* begin
		case (vector_hits)
			3'h4, 3'h5, 3'h6, 3'h7: begin
				next_vector = `IRVM_VEC_NMI;
			end
			3'h2, 3'h3: begin
				next_vector = `IRVM_VEC_VLM;
			end
			3'h1: begin
				next_vector = `IRVM_VEC_RTC;
			end
			default: begin
				next_vector = `IRVM_VEC_RESET;
			end
		endcase
	end

	// word address of the selected vector
	always @* begin
		case (next_vector)
			`IRVM_VEC_NMI: begin
				next_address = `IRVM_ADDR_NMI;
			end
			`IRVM_VEC_VLM: begin
				next_address = `IRVM_ADDR_VLM;
			end
			`IRVM_VEC_RTC: begin
				next_address = `IRVM_ADDR_RTC;
			end
			default: begin
				next_address = `IRVM_ADDR_RESET;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs

	// flag view
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			INTERRUPT_FLAG_REGISTER <= `IRVM_FLAG_RST;
		end else begin
			INTERRUPT_FLAG_REGISTER <= next_flag_reg;
		end
	end

	// enable view
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			INTERRUPT_ENABLE_REGISTER <= `IRVM_EN_RST;
		end else begin
			INTERRUPT_ENABLE_REGISTER <= next_enable_reg;
		end
	end

	// memory scan nonmaskable request
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			MEMORY_SCAN_NONMASKABLE_IRQ <= 1'h0;
		end else begin
			MEMORY_SCAN_NONMASKABLE_IRQ <= next_nmi;
		end
	end

	// voltage level monitor request
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			VOLTAGE_LEVEL_MONITOR_IRQ <= 1'h0;
		end else begin
			VOLTAGE_LEVEL_MONITOR_IRQ <= next_vlm;
		end
	end

	// rtc counter request
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			RTC_COUNTER_IRQ <= 1'h0;
		end else begin
			RTC_COUNTER_IRQ <= next_rtc;
		end
	end

	// any request pending
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			IRQ_PENDING <= 1'h0;
		end else begin
			IRQ_PENDING <= next_pending;
		end
	end

	// selected vector
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			IRQ_VECTOR <= `IRVM_VEC_RESET;
		end else begin
			IRQ_VECTOR <= next_vector;
		end
	end

	// selected word address, reset entry after any reset
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			IRQ_ADDRESS <= `IRVM_ADDR_RESET;
		end else begin
			IRQ_ADDRESS <= next_address;
		end
	end

endmodule

`default_nettype wire

// file: verif/interrupt_request_vector_map_tb_top.sv
/* bench for irvm_top with the core model.
 needs the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_vector_map_tb_top;
	logic            CLOCK = 1'h0, SYS_RST = 1'h1, g = 1'h0;
	logic [3:0]      ev = 4'h0, cl = 4'h0, we = 4'h0, wv = 4'h0;
	wire logic [3:0] fl, en;
	wire logic       nm, vl, rt, pd;
	wire logic [1:0] vc;
	wire logic [7:0] ad, fe;
	int              failures = 0, comparisons = 0;
	irvm_top i_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SCAN_FAIL(ev[0]), .VLM_EVENT(ev[1]),
		.RTC_OVF_EVENT(ev[2]), .RTC_CMP_EVENT(ev[3]), .FLAG_CLEAR(cl), .ENABLE_WRITE(we),
		.ENABLE_VALUE(wv), .GLOBAL_ENABLE(g), .INTERRUPT_FLAG_REGISTER(fl),
		.INTERRUPT_ENABLE_REGISTER(en), .MEMORY_SCAN_NONMASKABLE_IRQ(nm),
		.VOLTAGE_LEVEL_MONITOR_IRQ(vl), .RTC_COUNTER_IRQ(rt), .IRQ_PENDING(pd),
		.IRQ_VECTOR(vc), .IRQ_ADDRESS(ad));
	irvm_core_model i_core (.clk(CLOCK), .rst(SYS_RST), .pending(pd), .address(ad), .fetch(fe));
	initial forever #20 CLOCK = ~CLOCK;
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task automatic chk(input string s, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic close_out;
		if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic pulse(input logic [3:0] e, c, w, v);
		{ev, cl, we, wv} <= {e, c, w, v};
		tick(1);
		{ev, cl, we} <= 12'h000;
		tick(1);
	endtask
	task automatic see(input logic [3:0] f, input logic [2:0] q, input logic [1:0] v);
		#1;
		chk("flags", {4'h0, fl}, {4'h0, f});
		chk("irqs", {4'h0, pd, nm, vl, rt}, {4'h0, |q, q});
		chk("address", ad, {5'h00, v, 1'h0});
		chk("vector", {6'h00, vc}, {6'h00, v});
		tick(1);
	endtask
	task automatic reset_entry(input int n);
		SYS_RST <= 1'h1;
		tick(n);
		SYS_RST <= 1'h0;
		tick(1);
		see(4'h0, 3'h0, 2'h0);
	endtask
	task automatic global_gate;
		pulse(4'h0, 4'h0, 4'hF, 4'h2);
		#1;
		chk("enables", {4'h0, en}, 8'h02);
		tick(1);
		pulse(4'h6, 4'h0, 4'h0, 4'h0);
		see(4'h6, 3'h0, 2'h0);
		g <= 1'h1;
		tick(1);
		see(4'h6, 3'h2, 2'h2);
		tick(6);
		#1;
		chk("fetch", fe, 8'h04);
		see(4'h6, 3'h2, 2'h2);
		pulse(4'h0, 4'h2, 4'h0, 4'h0);
		see(4'h4, 3'h0, 2'h0);
	endtask
	task automatic nmi_and_rtc;
		g <= 1'h0;
		pulse(4'h3, 4'h0, 4'hF, 4'hD);
		see(4'h7, 3'h4, 2'h1);
		g <= 1'h1;
		pulse(4'h0, 4'h1, 4'h0, 4'h0);
		see(4'h6, 3'h1, 2'h3);
		pulse(4'h8, 4'h4, 4'h0, 4'h0);
		see(4'hA, 3'h1, 2'h3);
		pulse(4'h4, 4'h4, 4'h0, 4'h0);
		see(4'hE, 3'h1, 2'h3);
		pulse(4'h0, 4'h0, 4'h8, 4'h0);
		#1;
		chk("enables", {4'h0, en}, 8'h05);
		tick(1);
	endtask
	initial begin
		reset_entry(12);
		global_gate();
		nmi_and_rtc();
		reset_entry(2);
		close_out();
	end
endmodule
`default_nettype wire

// file: verif/irvm_chk.sv
/* checker: gating and vector map of irvm_top.
 bound to irvm_top, sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module irvm_chk (
	input wire logic       CLOCK, SYS_RST, VLM_EVENT, GLOBAL_ENABLE,
	input wire logic [3:0] FLAG_CLEAR, INTERRUPT_FLAG_REGISTER, INTERRUPT_ENABLE_REGISTER,
	input wire logic       MEMORY_SCAN_NONMASKABLE_IRQ, VOLTAGE_LEVEL_MONITOR_IRQ,
	input wire logic       RTC_COUNTER_IRQ,
	input wire logic [1:0] IRQ_VECTOR,
	input wire logic [7:0] IRQ_ADDRESS
);
	wire logic [3:0] f = INTERRUPT_FLAG_REGISTER;
	wire logic [3:0] e = INTERRUPT_ENABLE_REGISTER;
	wire logic       m = MEMORY_SCAN_NONMASKABLE_IRQ;
	wire logic       v = VOLTAGE_LEVEL_MONITOR_IRQ;
	wire logic       r = RTC_COUNTER_IRQ;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	sequence s_set; ##2 f[1]; endsequence
	sequence s_gone; ##2 !f[1]; endsequence
	AST_SET: assert property (VLM_EVENT |-> s_set)
		else $error("flag not set");
	AST_CLR: assert property (FLAG_CLEAR[1] && !VLM_EVENT |-> s_gone)
		else $error("flag not cleared");
	AST_HOLD: assert property (f[1] && !$past(FLAG_CLEAR[1]) |=> f[1])
		else $error("flag lost");
	AST_NMI: assert property (m == (f[0] & e[0]))
		else $error("nmi gating");
	AST_VLM: assert property (v == (f[1] & e[1] & $past(GLOBAL_ENABLE)))
		else $error("vlm gating");
	AST_RTC: assert property (r == ((f[2] & e[2] | f[3] & e[3]) & $past(GLOBAL_ENABLE)))
		else $error("rtc gating");
	AST_VEC: assert property (IRQ_VECTOR == (m ? 2'h1 : v ? 2'h2 : r ? 2'h3 : 2'h0))
		else $error("vector");
	AST_ADR: assert property (IRQ_ADDRESS == {5'h00, IRQ_VECTOR, 1'h0})
		else $error("address");
	AST_RST: assert property ($fell(SYS_RST) |-> IRQ_ADDRESS == 8'h00)
		else $error("reset entry");
endmodule
bind irvm_top irvm_chk i_chk (.*);
`default_nettype wire

// file: verif/irvm_core_model.sv
/* core model: fetches the word address of a pending vector.
 same clock as irvm_top. */
`timescale 1ns/1ps
`default_nettype none
module irvm_core_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       pending,
	input  wire logic [7:0] address,
	output var  logic [7:0] fetch
);
	// reset entry or vector word
	always @(posedge clk) begin
		fetch <= (rst || !pending) ? 8'h00 : address;
	end
endmodule
`default_nettype wire
